// [logic/startup_decode.sv]
// turns the start-up field codes into physical values, one cycle after a change
`timescale 1ns/10ps
`include "startup_cfg_params.svh"
module startup_decode (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // link to the register bank
  startup_cfg_link_if.dec  link
);
  import startup_cfg_pkg::*;

  dec_state_t state_reg;
  dec_state_t state_next;

  function automatic angle_deg_t angle_of(input logic [4:0] code);
    angle_deg_t a;
    a = 9'h000;
    case (code)
      5'h00: a = 9'd0;
      5'h01: a = 9'd10;
      5'h02: a = 9'd20;
      5'h03: a = 9'd30;
      5'h04: a = 9'd45;
      5'h05: a = 9'd60;
      5'h06: a = 9'd70;
      5'h07: a = 9'd80;
      5'h08: a = 9'd90;
      5'h09: a = 9'd110;
      5'h0A: a = 9'd120;
      5'h0B: a = 9'd135;
      5'h0C: a = 9'd150;
      5'h0D: a = 9'd160;
      5'h0E: a = 9'd170;
      5'h0F: a = 9'd180;
      5'h10: a = 9'd190;
      5'h11: a = 9'd210;
      5'h12: a = 9'd225;
      5'h13: a = 9'd240;
      5'h14: a = 9'd250;
      5'h15: a = 9'd260;
      5'h16: a = 9'd270;
      5'h17: a = 9'd280;
      5'h18: a = 9'd290;
      5'h19: a = 9'd300;
      5'h1A: a = 9'd315;
      5'h1B: a = 9'd340;
      5'h1C: a = 9'd350;
      default: a = 9'd0;
    endcase
    return a;
  endfunction

  function automatic pct_x10_t pct_of(input logic [3:0] code);
    pct_x10_t p;
    p = 10'h000;
    case (code)
      4'h0: p = 10'd10;
      4'h1: p = 10'd20;
      4'h2: p = 10'd30;
      4'h3: p = 10'd50;
      4'h4: p = 10'd75;
      4'h5: p = 10'd100;
      4'h6: p = 10'd125;
      4'h7: p = 10'd150;
      4'h8: p = 10'd175;
      4'h9: p = 10'd200;
      4'hA: p = 10'd250;
      4'hB: p = 10'd300;
      4'hC: p = 10'd350;
      4'hD: p = 10'd400;
      4'hE: p = 10'd450;
      default: p = 10'd500;
    endcase
    return p;
  endfunction

  function automatic ramp_x100_t ramp_of(input logic [2:0] code);
    ramp_x100_t r;
    r = 8'h00;
    case (code)
      3'h0: r = 8'd1;
      3'h1: r = 8'd5;
      3'h2: r = 8'd10;
      3'h3: r = 8'd15;
      3'h4: r = 8'd20;
      3'h5: r = 8'd50;
      3'h6: r = 8'd100;
      default: r = 8'd200;
    endcase
    return r;
  endfunction

  always_comb begin
    state_next = state_reg;
    state_next.angle = angle_of(link.su_word[`SU_ANGLE_MSB:`SU_ANGLE_LSB]);
    // reserved codes park the angle at zero and raise a flag, never an undefined angle
    state_next.angle_reserved = link.su_word[`SU_ANGLE_MSB:`SU_ANGLE_LSB] > `ANGLE_LAST_VALID;
    state_next.spin_pct = pct_of(link.su_word[`SU_SPIN_PCT_MSB:`SU_SPIN_PCT_LSB]);
    state_next.first_pct = link.su_word[`SU_SPIN_CHOICE_BIT] ? state_next.spin_pct : 10'h000;
    state_next.ramp = ramp_of(link.su_word[`SU_RAMP_MSB:`SU_RAMP_LSB]);
    if (srst_i) begin
      state_next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end

  assign link.angle          = state_reg.angle;
  assign link.angle_reserved = state_reg.angle_reserved;
  assign link.spin_pct       = state_reg.spin_pct;
  assign link.first_pct      = state_reg.first_pct;
  assign link.ramp           = state_reg.ramp;

  a_angle_ninety: assert property (@(posedge clk_i) disable iff (srst_i)
    (link.su_word[12:8] == 5'h08) |=> (link.angle == 9'd90 && !link.angle_reserved))
    else $error("align code 8h did not give 90 degrees");
  a_angle_half_turn: assert property (@(posedge clk_i) disable iff (srst_i)
    (link.su_word[12:8] == 5'h0F) |=> (link.angle == 9'd180))
    else $error("align code Fh did not give 180 degrees");
  a_spin_pct_ends: assert property (@(posedge clk_i) disable iff (srst_i)
    (link.su_word[7:4] == 4'h0) |=> (link.spin_pct == 10'd10))
    else $error("spin code 0h did not give 1 percent");
  a_first_cycle_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    !link.su_word[3] |=> (link.first_pct == 10'h000))
    else $error("first cycle not zero hertz when choice is clear");
  a_first_cycle_pct: assert property (@(posedge clk_i) disable iff (srst_i)
    (link.su_word[3] && link.su_word[7:4] == 4'hF) |=> (link.first_pct == 10'd500))
    else $error("first cycle not 50 percent for code Fh");
  a_ramp_rate_ends: assert property (@(posedge clk_i) disable iff (srst_i)
    (link.su_word[2:0] == 3'h7) |=> (link.ramp == 8'd200))
    else $error("ramp code 7h did not give 2 deg/ms");
  a_ramp_rate_low: assert property (@(posedge clk_i) disable iff (srst_i)
    (link.su_word[2:0] == 3'h0) |=> (link.ramp == 8'd1))
    else $error("ramp code 0h did not give 0.01 deg/ms");
endmodule

// [logic/startup_cfg_params.svh]
// register offsets, field positions, reset values and encodings of the settings bank
`ifndef STARTUP_CFG_PARAMS_SVH
`define STARTUP_CFG_PARAMS_SVH

`define ADDR_W              12
`define CL_SETTINGS_OFS     12'h088
`define SU_SETTINGS_OFS     12'h084

`define CL_RESET_VAL        32'h00000000
`define SU_RESET_VAL        13'h0000

`define SU_ANGLE_MSB        12
`define SU_ANGLE_LSB        8
`define SU_SPIN_PCT_MSB     7
`define SU_SPIN_PCT_LSB     4
`define SU_SPIN_CHOICE_BIT  3
`define SU_RAMP_MSB         2
`define SU_RAMP_LSB         0
`define SU_WORD_W           13

`define CL_OVERMOD_BIT      30
`define CL_ACCEL_MSB        29
`define CL_ACCEL_LSB        25
`define CL_DECEL_SRC_BIT    24
`define CL_DECEL_MSB        23
`define CL_DECEL_LSB        19

`define ANGLE_LAST_VALID    5'h1C

`endif

// [logic/startup_cfg_pkg.sv]
// types shared by the settings bank and its start-up decoder
package startup_cfg_pkg;

  typedef logic [8:0] angle_deg_t;   // whole degrees
  typedef logic [9:0] pct_x10_t;     // tenths of a percent of top speed
  typedef logic [7:0] ramp_x100_t;   // hundredths of a degree per millisecond

  typedef struct packed {
    logic [31:0] cl;
    logic [12:0] su;
    logic [31:0] rdata;
  } bank_state_t;

  typedef struct packed {
    angle_deg_t angle;
    logic       angle_reserved;
    pct_x10_t   spin_pct;
    pct_x10_t   first_pct;
    ramp_x100_t ramp;
  } dec_state_t;

endpackage

// [logic/startup_cfg_link_if.sv]
// carries the start-up word to the decoder and the decoded values back
`timescale 1ns/10ps
interface startup_cfg_link_if;
  import startup_cfg_pkg::*;

  logic [12:0] su_word;
  angle_deg_t  angle;
  logic        angle_reserved;
  pct_x10_t    spin_pct;
  pct_x10_t    first_pct;
  ramp_x100_t  ramp;

  modport bank (
    output su_word,
    input  angle,
    input  angle_reserved,
    input  spin_pct,
    input  first_pct,
    input  ramp
  );

  modport dec (
    input  su_word,
    output angle,
    output angle_reserved,
    output spin_pct,
    output first_pct,
    output ramp
  );
endinterface

// [logic/startup_cfg_bank.sv]
// apb register bank holding the start-up tail and closed-loop settings words
`timescale 1ns/10ps
`include "startup_cfg_params.svh"
module startup_cfg_bank (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         srst_i,
  // apb slave
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [11:0]                  paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  output logic                              pready_o,
  output logic [31:0]                       prdata_o,
  output logic                              pslverr_o,
  // closed-loop controls
  output logic                              overmod_en_o,
  output logic [4:0]                        feedback_accel_rate_o,
  output logic                              feedback_decel_source_o,
  output logic [4:0]                        feedback_decel_rate_o,
  output logic [31:0]                       closed_loop_word_o,
  // start-up controls
  output startup_cfg_pkg::angle_deg_t       align_angle_deg_o,
  output logic                              align_code_reserved_o,
  output startup_cfg_pkg::pct_x10_t         initial_spin_rate_pct_o,
  output logic                              initial_spin_rate_choice_o,
  output startup_cfg_pkg::pct_x10_t         first_cycle_pct_o,
  output startup_cfg_pkg::ramp_x100_t       theta_merge_rate_o
);
  import startup_cfg_pkg::*;

  bank_state_t state_reg;
  bank_state_t state_next;

  startup_cfg_link_if link ();

  logic        setup_phase;
  logic        access_phase;
  logic        hit_cl;
  logic        hit_su;
  logic        mapped;
  logic        wr_cl;
  logic        wr_su;
  logic [31:0] strobe_mask;
  logic [31:0] su_wide;

  assign hit_cl       = (paddr_i == `CL_SETTINGS_OFS);
  assign hit_su       = (paddr_i == `SU_SETTINGS_OFS);
  assign mapped       = hit_cl | hit_su;
  assign setup_phase  = psel_i & ~penable_i;
  assign access_phase = psel_i & penable_i;
  // zero wait states: every access completes in its first access cycle
  assign wr_cl        = access_phase & pwrite_i & hit_cl;
  assign wr_su        = access_phase & pwrite_i & hit_su;
  assign su_wide      = {19'h00000, state_reg.su};

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign strobe_mask[lane*8 +: 8] = {8{pstrb_i[lane]}};
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    if (wr_cl) begin
      state_next.cl = (state_reg.cl & ~strobe_mask) | (pwdata_i & strobe_mask);
    end
    // only bits 12:0 exist in the start-up slice; the rest read as zero
    if (wr_su) begin
      state_next.su = (state_reg.su & ~strobe_mask[12:0]) | (pwdata_i[12:0] & strobe_mask[12:0]);
    end
    // read data is captured in setup so prdata is a flop during access
    if (setup_phase && !pwrite_i) begin
      state_next.rdata = hit_cl ? state_reg.cl : (hit_su ? su_wide : 32'h00000000);
    end
    if (srst_i) begin
      state_next.cl    = `CL_RESET_VAL;
      state_next.su    = `SU_RESET_VAL;
      state_next.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end

  // apb answer
  assign pready_o  = 1'b1;
  assign pslverr_o = access_phase & ~mapped;
  assign prdata_o  = state_reg.rdata;

  assign overmod_en_o            = state_reg.cl[`CL_OVERMOD_BIT];
  assign feedback_accel_rate_o   = state_reg.cl[`CL_ACCEL_MSB:`CL_ACCEL_LSB];
  assign feedback_decel_source_o = state_reg.cl[`CL_DECEL_SRC_BIT];
  assign feedback_decel_rate_o   = state_reg.cl[`CL_DECEL_MSB:`CL_DECEL_LSB];
  assign closed_loop_word_o      = state_reg.cl;

  assign link.su_word = state_reg.su;

  startup_decode u_decode (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .link   (link)
  );

  assign align_angle_deg_o          = link.angle;
  assign align_code_reserved_o      = link.angle_reserved;
  assign initial_spin_rate_pct_o    = link.spin_pct;
  assign initial_spin_rate_choice_o = state_reg.su[`SU_SPIN_CHOICE_BIT];
  assign first_cycle_pct_o          = link.first_pct;
  assign theta_merge_rate_o         = link.ramp;

  a_cl_reset_zero: assert property (@(posedge clk_i)
    srst_i |=> (closed_loop_word_o == 32'h00000000 && !overmod_en_o))
    else $error("closed-loop word not zero after reset");
  a_cl_write_lands: assert property (@(posedge clk_i) disable iff (srst_i)
    (psel_i && penable_i && pwrite_i && paddr_i == 12'h088 && pstrb_i == 4'hF)
      |=> (closed_loop_word_o == $past(pwdata_i)))
    else $error("full write to closed-loop word did not land");
  a_cl_read_back: assert property (@(posedge clk_i) disable iff (srst_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == 12'h088)
      |=> (prdata_o == $past(closed_loop_word_o)))
    else $error("closed-loop read data wrong");
  a_overmod_enable: assert property (@(posedge clk_i) disable iff (srst_i)
    (psel_i && penable_i && pwrite_i && paddr_i == 12'h088 && pstrb_i[3])
      |=> (overmod_en_o == $past(pwdata_i[30])))
    else $error("overmodulation enable did not follow bit 30");
  a_decel_fields: assert property (@(posedge clk_i) disable iff (srst_i)
    (psel_i && penable_i && pwrite_i && paddr_i == 12'h088 && pstrb_i == 4'hF)
      |=> (feedback_accel_rate_o == $past(pwdata_i[29:25])
           && feedback_decel_source_o == $past(pwdata_i[24])
           && feedback_decel_rate_o == $past(pwdata_i[23:19])))
    else $error("closed-loop fields misplaced");
  a_angle_path: assert property (@(posedge clk_i) disable iff (srst_i)
    (psel_i && penable_i && pwrite_i && paddr_i == 12'h084 && pstrb_i[1]
      && pwdata_i[12:8] == 5'h08) |=> ##1 (align_angle_deg_o == 9'd90))
    else $error("written align code 8h not seen as 90 degrees");
  a_unmapped_error: assert property (@(posedge clk_i) disable iff (srst_i)
    (psel_i && penable_i && paddr_i != 12'h088 && paddr_i != 12'h084)
      |-> pslverr_o ##1 $stable(closed_loop_word_o))
    else $error("unmapped access not flagged");
endmodule

// [tb/motor_startup_closed_loop_cfg_test.sv]
// self-checking bench for the start-up and closed-loop settings bank
`timescale 1ns/10ps
`include "startup_cfg_params.svh"
module motor_startup_closed_loop_cfg_test;
  logic        clk_i = 0;
  logic        srst_i = 1;
  logic        psel_i = 0;
  logic        penable_i = 0;
  logic        pwrite_i = 0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [3:0]  pstrb_i = 4'hF;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        overmod_en_o;
  logic [4:0]  feedback_accel_rate_o;
  logic        feedback_decel_source_o;
  logic [4:0]  feedback_decel_rate_o;
  logic [31:0] closed_loop_word_o;
  logic [8:0]  align_angle_deg_o;
  logic        align_code_reserved_o;
  logic [9:0]  initial_spin_rate_pct_o;
  logic        initial_spin_rate_choice_o;
  logic [9:0]  first_cycle_pct_o;
  logic [7:0]  theta_merge_rate_o;
  int          n_fail = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h0001151E;
  logic [31:0] cl_m = 32'h00000000;
  logic [31:0] su_m = 32'h00000000;
  logic [31:0] rd;
  logic [31:0] wd;
  logic        er;
  logic [3:0]  s;
  // reserved alignment codes decode to zero degrees
  int ang_t[32] = '{0, 10, 20, 30, 45, 60, 70, 80, 90, 110, 120, 135, 150, 160, 170, 180,
                    190, 210, 225, 240, 250, 260, 270, 280, 290, 300, 315, 340, 350, 0, 0, 0};
  int pct_t[16] = '{10, 20, 30, 50, 75, 100, 125, 150, 175, 200, 250, 300, 350, 400, 450, 500};
  int ramp_t[8] = '{1, 5, 10, 15, 20, 50, 100, 200};

  startup_cfg_bank startup_cfg_bank_inst (
    .clk_i                      (clk_i),
    .srst_i                     (srst_i),
    .psel_i                     (psel_i),
    .penable_i                  (penable_i),
    .pwrite_i                   (pwrite_i),
    .paddr_i                    (paddr_i),
    .pwdata_i                   (pwdata_i),
    .pstrb_i                    (pstrb_i),
    .pready_o                   (pready_o),
    .prdata_o                   (prdata_o),
    .pslverr_o                  (pslverr_o),
    .overmod_en_o               (overmod_en_o),
    .feedback_accel_rate_o      (feedback_accel_rate_o),
    .feedback_decel_source_o    (feedback_decel_source_o),
    .feedback_decel_rate_o      (feedback_decel_rate_o),
    .closed_loop_word_o         (closed_loop_word_o),
    .align_angle_deg_o          (align_angle_deg_o),
    .align_code_reserved_o      (align_code_reserved_o),
    .initial_spin_rate_pct_o    (initial_spin_rate_pct_o),
    .initial_spin_rate_choice_o (initial_spin_rate_choice_o),
    .first_cycle_pct_o          (first_cycle_pct_o),
    .theta_merge_rate_o         (theta_merge_rate_o)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction

  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // entered just after a rising edge; leaves one idle cycle behind the transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st, output logic [31:0] r, output logic e);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= st;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    r = prdata_o;
    e = pslverr_o;
    if (n >= 20) chk("pready", 32'h00000001, {31'h0, pready_o});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk_dec();
    chk("angle", ang_t[su_m[12:8]], {23'h0, align_angle_deg_o});
    chk("reserved", {31'h0, su_m[12:8] > 5'h1C}, {31'h0, align_code_reserved_o});
    chk("spin_pct", pct_t[su_m[7:4]], {22'h0, initial_spin_rate_pct_o});
    chk("choice", {31'h0, su_m[3]}, {31'h0, initial_spin_rate_choice_o});
    chk("first_pct", su_m[3] ? pct_t[su_m[7:4]] : 0, {22'h0, first_cycle_pct_o});
    chk("merge_rate", ramp_t[su_m[2:0]], {24'h0, theta_merge_rate_o});
  endtask

  task automatic chk_cl();
    chk("cl_word", cl_m, closed_loop_word_o);
    chk("overmod", {31'h0, cl_m[30]}, {31'h0, overmod_en_o});
    chk("accel", {27'h0, cl_m[29:25]}, {27'h0, feedback_accel_rate_o});
    chk("decel_src", {31'h0, cl_m[24]}, {31'h0, feedback_decel_source_o});
    chk("decel", {27'h0, cl_m[23:19]}, {27'h0, feedback_decel_rate_o});
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      // decoded values stay zero for one edge after reset, then show code 0
      @(posedge clk_i);
      chk("rst_spin", 32'h00000000, {22'h0, initial_spin_rate_pct_o});
      chk_cl();
      @(posedge clk_i);
      chk_dec();
      apb(1'b0, `CL_SETTINGS_OFS, 32'h00000000, 4'hF, rd, er);
      chk("cl_reset_read", 32'h00000000, rd);
      // reserved align codes 1Dh..1Fh are never written
      for (int i = 0; i < 29; i++) begin
        seed = lfsr(seed);
        wd = {seed[31:13], i[4:0], i[3:0], seed[3], i[2:0]};
        apb(1'b1, `SU_SETTINGS_OFS, wd, 4'hF, rd, er);
        su_m = wd & 32'h00001FFF;
        @(posedge clk_i);
        chk_dec();
        apb(1'b0, `SU_SETTINGS_OFS, 32'h00000000, 4'hF, rd, er);
        chk("su_read", su_m, rd);
      end
      for (int i = 0; i < 16; i++) begin
        seed = lfsr(seed);
        wd = seed;
        wd[30] = i[0];
        s = i[3] ? seed[11:8] : 4'hF;
        apb(1'b1, `CL_SETTINGS_OFS, wd, s, rd, er);
        cl_m = merge(cl_m, wd, s);
        chk("cl_err", 32'h00000000, {31'h0, er});
        chk_cl();
        apb(1'b0, `CL_SETTINGS_OFS, 32'h00000000, 4'hF, rd, er);
        chk("cl_read", cl_m, rd);
      end
      // unmapped place: refused, nothing stored
      apb(1'b1, 12'h08C, seed, 4'hF, rd, er);
      chk("unmapped_wr_err", 32'h00000001, {31'h0, er});
      apb(1'b0, 12'h08C, 32'h00000000, 4'hF, rd, er);
      chk("unmapped_rd", 32'h00000000, rd);
      chk("unmapped_rd_err", 32'h00000001, {31'h0, er});
      apb(1'b0, `CL_SETTINGS_OFS, 32'h00000000, 4'hF, rd, er);
      chk("cl_kept", cl_m, rd);
      // second pass starts from a reset in mid-run
      srst_i <= 1'b1;
      @(posedge clk_i);
      srst_i <= 1'b0;
      cl_m = 32'h00000000;
      su_m = 32'h00000000;
    end
    complete_run();
  end
endmodule
